// ===== design/tccu_capture_compare.sv
// input capture and two-channel output compare of a 16-bit timer
`timescale 1ns/1ps
`default_nettype none
module tccu_capture_compare
  import tccu_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // timer context
  input  wire logic              timerTick,
  input  wire logic [15:0]       counterValue,
  input  wire logic              counterWrite,
  input  wire logic              atTop,
  input  wire logic              atBottom,
  input  wire logic [MODE_W-1:0] waveformMode,
  // capture control
  input  wire logic              capturePin,
  input  wire logic              comparatorOutput,
  input  wire logic              comparatorCaptureSelect,
  input  wire logic              captureFilterEnable,
  input  wire logic              captureEdgeRising,
  input  wire logic              captureIrqEnable,
  input  wire logic              captureIrqAck,
  input  wire logic              captureFlagClear,
  // compare control
  input  wire logic [1:0]        compareIrqEnable,
  input  wire logic [1:0]        compareIrqAck,
  input  wire logic [1:0]        compareFlagClear,
  input  wire logic [1:0]        forceStrobe,
  input  wire logic [COM_W-1:0]  compareOutputModeA,
  input  wire logic [COM_W-1:0]  compareOutputModeB,
  // 8-bit register port
  input  wire logic              regRead,
  input  wire logic              regWrite,
  input  wire tccu_sel_t         regSel,
  input  wire logic [7:0]        regWdata,
  output logic [7:0]             regRdata,
  // status and outputs
  output logic [15:0]            captureValue,
  output logic                   captureFlag,
  output logic                   captureIrq,
  output logic [1:0]             compareFlag,
  output logic [1:0]             compareIrq,
  output logic [1:0]             compareOutput,
  output logic [15:0]            topValueA
);
  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  function automatic logic isPwm(input logic [MODE_W-1:0] m);
    return !(m == MODE_NORMAL || m == MODE_CTC_A || m == MODE_CTC_CAP || m == MODE_RSVD);
  endfunction

  function automatic logic capIsTop(input logic [MODE_W-1:0] m);
    return m == 4'h8 || m == 4'ha || m == MODE_CTC_CAP || m == 4'he;
  endfunction

  wire pwmMode     = isPwm(waveformMode);
  wire captureLive = !capIsTop(waveformMode);
  // dual-slope modes reload at bottom, single-slope at top
  wire dualSlope   = (waveformMode >= 4'h1 && waveformMode <= 4'h3) ||
                     (waveformMode >= 4'h8 && waveformMode <= 4'hb);
  wire reloadPoint = timerTick && (dualSlope ? atBottom : atTop);

  // ----------------------------------------
  // capture trigger path
  // ----------------------------------------
  // the pin is sampled as a level, so port-driven changes capture too
  wire triggerSrc = comparatorCaptureSelect ? comparatorOutput : capturePin;

  tccu_filt_if filtLink ();
  assign filtLink.sampleIn = triggerSrc;
  assign filtLink.enable   = captureFilterEnable;

  // adds the four-cycle delay when enabled
  tccu_noise_filter #(
    .SAMPLES (FILTER_SAMPLES)
  ) u_filter (
    .clk    (clk),
    .arst_n (arst_n),
    .link   (filtLink.filter)
  );

  logic edgePrev_reg;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      edgePrev_reg <= 1'b0;
    else
      edgePrev_reg <= filtLink.filtered;

  // a source switch shows as an edge here; software clears the flag
  wire riseSeen   = filtLink.filtered && !edgePrev_reg;
  wire fallSeen   = !filtLink.filtered && edgePrev_reg;
  wire captureHit = captureLive && (captureEdgeRising ? riseSeen : fallSeen);

  // ----------------------------------------
  // capture register and flag
  // ----------------------------------------
  logic [15:0] capture_reg;
  logic        capFlag_reg;

  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      capture_reg <= CAPTURE_RST;
    else if (captureHit)
      capture_reg <= counterValue;

  // set wins over a clear in the same cycle; software clears by writing one
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      capFlag_reg <= 1'b0;
    else if (captureHit)
      capFlag_reg <= 1'b1;
    else if (captureFlagClear || captureIrqAck)
      capFlag_reg <= 1'b0;

  // ----------------------------------------
  // byte access decode and shared latch
  // ----------------------------------------
  wire wrHighA  = regWrite && regSel == SEL_CMPA_HIGH;
  wire wrHighB  = regWrite && regSel == SEL_CMPB_HIGH;
  wire wrHighC  = regWrite && regSel == SEL_CAP_HIGH;
  wire rdCapLow = regRead && regSel == SEL_CAP_LOW;
  wire [1:0] wrLow = {regWrite && regSel == SEL_CMPB_LOW,
                      regWrite && regSel == SEL_CMPA_LOW};

  logic [7:0] latch_reg;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      latch_reg <= LATCH_RST;
    else if (wrHighA || wrHighB || wrHighC)
      latch_reg <= regWdata;
    else if (rdCapLow)
      latch_reg <= capture_reg[15:8];

  // ----------------------------------------
  // compare channels
  // ----------------------------------------
  logic [15:0] cmp_reg  [2];
  logic [15:0] buf_reg  [2];
  logic [1:0]  cmpFlag_reg;
  logic [1:0]  ocState_reg;
  logic        block_reg;
  wire  [1:0]  matchNow;
  wire  [COM_W-1:0] comMode [2];
  assign comMode[0] = compareOutputModeA;
  assign comMode[1] = compareOutputModeB;

  // a counter write blocks matches over the following timer tick
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      block_reg <= 1'b0;
    else if (counterWrite)
      block_reg <= 1'b1;
    else if (timerTick)
      block_reg <= 1'b0;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_chan
      wire [15:0] newWord  = {latch_reg, regWdata};
      // with the block a counter written equal to the compare value misses that match
      assign matchNow[ch] = timerTick && !block_reg && !counterWrite &&
                            counterValue == cmp_reg[ch];
      wire forceHit = forceStrobe[ch] && !pwmMode;

      // writes go to the buffer in PWM modes, else straight
      always_ff @(posedge clk or negedge arst_n)
        if (!arst_n)
          buf_reg[ch] <= COMPARE_RST;
        else if (wrLow[ch])
          buf_reg[ch] <= newWord;

      always_ff @(posedge clk or negedge arst_n)
        if (!arst_n)
          cmp_reg[ch] <= COMPARE_RST;
        else if (wrLow[ch] && !pwmMode)
          cmp_reg[ch] <= newWord;
        else if (pwmMode && reloadPoint)
          cmp_reg[ch] <= buf_reg[ch];

      // flag registered at the end of the tick that sees equality; set wins over clear
      always_ff @(posedge clk or negedge arst_n)
        if (!arst_n)
          cmpFlag_reg[ch] <= 1'b0;
        else if (matchNow[ch])
          cmpFlag_reg[ch] <= 1'b1;
        else if (compareFlagClear[ch] || compareIrqAck[ch])
          cmpFlag_reg[ch] <= 1'b0;

      // mode bits read live each cycle; state kept across mode change
      wire act = matchNow[ch] || forceHit;
      always_ff @(posedge clk or negedge arst_n)
        if (!arst_n)
          ocState_reg[ch] <= 1'b0;
        else if (act)
          case (comMode[ch])
            COM_TOGGLE: ocState_reg[ch] <= !ocState_reg[ch];
            COM_CLEAR:  ocState_reg[ch] <= 1'b0;
            COM_SET:    ocState_reg[ch] <= 1'b1;
            default:    ocState_reg[ch] <= ocState_reg[ch];
          endcase
    end
  endgenerate

  // ----------------------------------------
  // read data and outputs
  // ----------------------------------------
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  always_comb
  begin
    case (regSel)
      SEL_CAP_LOW:   rdata_next = capture_reg[7:0];
      SEL_CAP_HIGH:  rdata_next = latch_reg;
      SEL_CMPA_LOW:  rdata_next = pwmMode ? buf_reg[0][7:0] : cmp_reg[0][7:0];
      SEL_CMPA_HIGH: rdata_next = pwmMode ? buf_reg[0][15:8] : cmp_reg[0][15:8];
      SEL_CMPB_LOW:  rdata_next = pwmMode ? buf_reg[1][7:0] : cmp_reg[1][7:0];
      SEL_CMPB_HIGH: rdata_next = pwmMode ? buf_reg[1][15:8] : cmp_reg[1][15:8];
      default:       rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      rdata_reg <= 8'h00;
    else if (regRead)
      rdata_reg <= rdata_next;

  assign regRdata      = rdata_reg;
  assign captureValue  = capture_reg;
  assign captureFlag   = capFlag_reg;
  assign captureIrq    = capFlag_reg && captureIrqEnable;
  assign compareFlag   = cmpFlag_reg;
  assign compareIrq    = cmpFlag_reg & compareIrqEnable;
  assign compareOutput = ocState_reg;
  assign topValueA     = cmp_reg[0];
endmodule
`default_nettype wire

// ===== pkg/tccu_pkg.sv
// package of constants and types for the timer capture/compare block
package tccu_pkg;
  // ----------------------------------------
  // widths and counts
  // ----------------------------------------
  localparam int FILTER_SAMPLES = 4;
  localparam int MODE_W         = 4;
  localparam int COM_W          = 2;

  // ----------------------------------------
  // reset values and counter maximum
  // ----------------------------------------
  localparam logic [15:0] CAPTURE_RST = 16'h0000;
  localparam logic [15:0] COMPARE_RST = 16'h0000;
  localparam logic [7:0]  LATCH_RST   = 8'h00;
  localparam logic [15:0] COUNT_MAX   = 16'hffff;

  // ----------------------------------------
  // waveform modes referenced by the logic
  // ----------------------------------------
  localparam logic [MODE_W-1:0] MODE_NORMAL   = 4'h0;
  localparam logic [MODE_W-1:0] MODE_CTC_A    = 4'h4;
  localparam logic [MODE_W-1:0] MODE_CTC_CAP  = 4'hc;
  localparam logic [MODE_W-1:0] MODE_RSVD     = 4'hd;

  // ----------------------------------------
  // compare output actions
  // ----------------------------------------
  localparam logic [COM_W-1:0] COM_NONE   = 2'h0;
  localparam logic [COM_W-1:0] COM_TOGGLE = 2'h1;
  localparam logic [COM_W-1:0] COM_CLEAR  = 2'h2;
  localparam logic [COM_W-1:0] COM_SET    = 2'h3;

  // byte access selector for the 8-bit register port
  typedef enum logic [2:0] {
    SEL_CAP_LOW,
    SEL_CAP_HIGH,
    SEL_CMPA_LOW,
    SEL_CMPA_HIGH,
    SEL_CMPB_LOW,
    SEL_CMPB_HIGH,
    SEL_NONE
  } tccu_sel_t;
endpackage

// ===== pkg/tccu_filt_if.sv
// interface between the capture path and its noise filter
`timescale 1ns/1ps
`default_nettype none
interface tccu_filt_if;
  logic sampleIn;
  logic enable;
  logic filtered;
  modport owner  (output sampleIn, output enable, input filtered);
  modport filter (input sampleIn, input enable, output filtered);
endinterface
`default_nettype wire

// ===== design/tccu_noise_filter.sv
// four-sample noise filter for the capture trigger
`timescale 1ns/1ps
`default_nettype none
module tccu_noise_filter
  import tccu_pkg::*;
#(
  parameter int SAMPLES = FILTER_SAMPLES
)
(
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // filter link
  tccu_filt_if.filter link
);
  logic [SAMPLES-2:0] hist_reg;
  logic               out_reg;
  // the live sample is the newest of the window, so the output moves on the
  // edge of the last agreeing sample and the added delay stays at SAMPLES cycles
  wire  [SAMPLES-1:0] window  = {hist_reg, link.sampleIn};
  wire                allHigh = &window;
  wire                allLow  = ~|window;

  // history runs on the system clock, never on the prescaled tick
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      hist_reg <= '0;
    else
      hist_reg <= {hist_reg[SAMPLES-3:0], link.sampleIn};

  // output moves only when every stored sample agrees
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      out_reg <= 1'b0;
    else if (allHigh)
      out_reg <= 1'b1;
    else if (allLow)
      out_reg <= 1'b0;

  // bypassed while the enable is clear
  assign link.filtered = link.enable ? out_reg : link.sampleIn;
endmodule
`default_nettype wire

// ===== bench/tccu_cc_chk.sv
// concurrent checks on the capture/compare block ports
`timescale 1ns/1ps
`default_nettype none
module tccu_cc_chk
  import tccu_pkg::*;
(
  // clock, reset and timer context
  input wire logic              clk, arst_n, timerTick, counterWrite,
  input wire logic [15:0]       counterValue,
  input wire logic [MODE_W-1:0] waveformMode,
  // control
  input wire logic [1:0]        compareIrqEnable, compareFlagClear, forceStrobe,
  input wire logic [COM_W-1:0]  compareOutputModeA,
  input wire logic              regRead, regWrite,
  input wire tccu_sel_t         regSel,
  input wire logic [7:0]        regWdata,
  // observed outputs
  input wire logic [7:0]        regRdata,
  input wire logic [15:0]       captureValue, topValueA,
  input wire logic              captureFlag,
  input wire logic [1:0]        compareFlag, compareIrq, compareOutput
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic blockPend;
  wire  nonPwm = waveformMode inside {4'h0, 4'h4, 4'hc, 4'hd};
  wire  capTop = waveformMode inside {4'h8, 4'ha, 4'hc, 4'he};
  // a write on a tick cycle keeps the block pending over the next tick too
  wire  matchA = timerTick && counterValue == topValueA && !blockPend && !counterWrite;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)           blockPend <= 1'b0;
    else if (counterWrite) blockPend <= 1'b1;
    else if (timerTick)    blockPend <= 1'b0;
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_cap_stamp: assert property ($rose(captureFlag) |-> captureValue == $past(counterValue))
    else $error("capture value differs from counter");
  a_cap_top_off: assert property ($rose(captureFlag) |-> !(capTop && $past(capTop, 3)))
    else $error("capture taken in a capture-top mode");
  a_cmp_match: assert property (matchA && nonPwm |=> compareFlag[0])
    else $error("compare match did not set flag");
  a_cmp_block: assert property (timerTick && (blockPend || counterWrite) && !compareFlag[0]
    |=> !compareFlag[0])
    else $error("match not blocked after counter write");
  a_cmp_clear: assert property (compareFlag[0] && compareFlagClear[0] && !matchA |=> !compareFlag[0])
    else $error("compare flag not cleared");
  a_cmp_irq: assert property (compareIrq == (compareFlag & compareIrqEnable))
    else $error("compare irq wrong");
  a_force_flag: assert property (forceStrobe[0] && !matchA && !compareFlag[0] |=> !compareFlag[0])
    else $error("force set the compare flag");
  a_force_tgl: assert property (forceStrobe[0] && nonPwm && compareOutputModeA == COM_TOGGLE
    && !timerTick |=> compareOutput[0] != $past(compareOutput[0]))
    else $error("force did not toggle output");
  a_out_hold: assert property (!timerTick && forceStrobe == 2'h0 |=> $stable(compareOutput))
    else $error("compare output moved without cause");
  a_wr_low: assert property (regWrite && regSel == SEL_CMPA_LOW && nonPwm
    |=> topValueA[7:0] == $past(regWdata))
    else $error("low byte write not applied");
  a_rd_high: assert property (regRead && !regWrite && regSel == SEL_CMPA_HIGH && nonPwm
    |=> regRdata == $past(topValueA[15:8]))
    else $error("compare high read not direct");
  c_capture: cover property ($rose(captureFlag));
  c_match: cover property (matchA && nonPwm);
  c_force: cover property (forceStrobe[0] && nonPwm);
endmodule
bind tccu_capture_compare tccu_cc_chk i_chk (.clk, .arst_n, .timerTick, .counterWrite,
  .counterValue, .waveformMode, .compareIrqEnable, .compareFlagClear, .forceStrobe,
  .compareOutputModeA, .regRead, .regWrite, .regSel, .regWdata, .regRdata, .captureValue,
  .topValueA, .captureFlag, .compareFlag, .compareIrq, .compareOutput);
`default_nettype wire

// ===== bench/tccu_event_src.sv
// event source model for the capture pin and comparator output
`timescale 1ns/1ps
`default_nettype none
module tccu_event_src
(
  // trigger levels
  output logic capturePin,
  output logic comparatorOutput
);
  initial
  begin
    capturePin = 1'b0;
    comparatorOutput = 1'b0;
  end
  // the pin level is what counts, so a port write by software looks the same here
  task automatic drive(input logic pin, input logic cmp);
    capturePin = pin;
    comparatorOutput = cmp;
  endtask
endmodule
`default_nettype wire

// ===== bench/test_timer16_capture_compare.sv
// self-checking testbench of the capture/compare block
`timescale 1ns/1ps
`default_nettype none
module test_timer16_capture_compare;
  import tccu_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, timerTick = 1'b0, counterWrite = 1'b0;
  logic atTop = 1'b0, atBottom = 1'b0, capSel = 1'b0, filtEn = 1'b0, edgeRise = 1'b1;
  logic capIen = 1'b1, capAck = 1'b0, capClr = 1'b0, regRead = 1'b0, regWrite = 1'b0;
  logic [15:0] counterValue = 16'h0000;
  logic [MODE_W-1:0] mode = MODE_NORMAL;
  logic [1:0] cIen = 2'h0, cAck = 2'h0, cClr = 2'h0, frc = 2'h0;
  logic [COM_W-1:0] comA = COM_NONE, comB = COM_NONE;
  tccu_sel_t regSel = SEL_NONE;
  logic [7:0] regWdata = 8'h00, regRdata, d;
  logic [15:0] captureValue, topValueA;
  logic captureFlag, captureIrq, pin, cmp;
  logic [1:0] compareFlag, compareIrq, compareOutput;
  int bad_count = 0, num_checks = 0, n;
  always #5 clk = ~clk;
  tccu_event_src i_src (.capturePin(pin), .comparatorOutput(cmp));
  tccu_capture_compare i_dut (.clk(clk), .arst_n(arst_n), .timerTick(timerTick),
    .counterValue(counterValue), .counterWrite(counterWrite), .atTop(atTop),
    .atBottom(atBottom), .waveformMode(mode), .capturePin(pin), .comparatorOutput(cmp),
    .comparatorCaptureSelect(capSel), .captureFilterEnable(filtEn),
    .captureEdgeRising(edgeRise), .captureIrqEnable(capIen), .captureIrqAck(capAck),
    .captureFlagClear(capClr), .compareIrqEnable(cIen), .compareIrqAck(cAck),
    .compareFlagClear(cClr), .forceStrobe(frc), .compareOutputModeA(comA),
    .compareOutputModeB(comB), .regRead(regRead), .regWrite(regWrite), .regSel(regSel),
    .regWdata(regWdata), .regRdata(regRdata), .captureValue(captureValue),
    .captureFlag(captureFlag), .captureIrq(captureIrq), .compareFlag(compareFlag),
    .compareIrq(compareIrq), .compareOutput(compareOutput), .topValueA(topValueA));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic wr(input tccu_sel_t s, input logic [7:0] v);
    regSel = s; regWdata = v; regWrite = 1'b1; cyc(1); regWrite = 1'b0;
    // idle cycle so a following call never re-raises the strobe in the same step
    cyc(1);
  endtask
  task automatic rd(input tccu_sel_t s);
    regSel = s; regRead = 1'b1; cyc(1); regRead = 1'b0; d = regRdata;
    cyc(1);
  endtask
  // edges from the change to the flag, bounded
  task automatic waitCap(input int exp);
    for (n = 1; n <= 12; n++)
    begin
      @(posedge clk); #1;
      if (captureFlag === 1'b1) break;
    end
    if (n > 12) begin bad_count++; conclude(); end
    chk(16'(n), 16'(exp), "capture latency");
    cyc(1);
  endtask
  task automatic clearCap();
    capClr = 1'b1; cyc(1); capClr = 1'b0;
    chk(16'(captureFlag), 16'h0000, "capture flag clear");
  endtask
  task automatic tick(); timerTick = 1'b1; cyc(1); timerTick = 1'b0; endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    @(negedge clk) arst_n = 1'b1;
    chk(captureValue | topValueA, 16'h0000, "reset values");
    chk(16'({captureFlag, compareFlag, compareOutput}), 16'h0000, "reset flags");
    counterValue = 16'h0abc; i_src.drive(1'b1, 1'b0); waitCap(1);
    chk(captureValue, 16'h0abc, "capture stamp");
    chk(16'(captureIrq), 16'h0001, "capture irq");
    capAck = 1'b1; cyc(1); capAck = 1'b0;
    counterValue = 16'h0def; i_src.drive(1'b0, 1'b0); cyc(8);
    chk(16'(captureFlag), 16'h0000, "wrong polarity");
    edgeRise = 1'b0; i_src.drive(1'b1, 1'b0); cyc(4); i_src.drive(1'b0, 1'b0); waitCap(1);
    chk(captureValue, 16'h0def, "falling capture");
    i_src.drive(1'b1, 1'b0); cyc(4); counterValue = 16'h0fed; i_src.drive(1'b0, 1'b0); cyc(8);
    chk(captureValue, 16'h0fed, "overwrite");
    edgeRise = 1'b1; capSel = 1'b1; cyc(8); clearCap();
    i_src.drive(1'b1, 1'b0); cyc(8);
    chk(16'(captureFlag), 16'h0000, "pin ignored");
    i_src.drive(1'b1, 1'b1); waitCap(1);
    capSel = 1'b0; filtEn = 1'b1; i_src.drive(1'b0, 1'b0); cyc(8); clearCap();
    i_src.drive(1'b1, 1'b0); cyc(3); i_src.drive(1'b0, 1'b0); cyc(10);
    chk(16'(captureFlag), 16'h0000, "glitch filtered");
    i_src.drive(1'b1, 1'b0); waitCap(5);
    filtEn = 1'b0; clearCap(); mode = MODE_CTC_CAP; i_src.drive(1'b0, 1'b0); cyc(3);
    i_src.drive(1'b1, 1'b0); cyc(8);
    chk(16'(captureFlag), 16'h0000, "capture-top mode");
    mode = MODE_NORMAL;
    rd(SEL_CAP_LOW); chk(16'(d), 16'h00ed, "capture low");
    rd(SEL_CAP_HIGH); chk(16'(d), 16'h000f, "capture high");
    wr(SEL_CMPA_HIGH, 8'h12); wr(SEL_CMPA_LOW, 8'h34);
    chk(topValueA, 16'h1234, "compare write");
    rd(SEL_CAP_LOW); rd(SEL_CMPA_HIGH); chk(16'(d), 16'h0012, "compare high");
    counterValue = 16'h1234; comA = COM_TOGGLE; cIen = 2'h1; tick();
    chk(16'({compareFlag[0], compareIrq[0], compareOutput[0]}), 16'h0007, "match");
    cClr = 2'h1; cyc(1); cClr = 2'h0;
    chk(16'(compareFlag), 16'h0000, "flag clear");
    counterWrite = 1'b1; cyc(1); counterWrite = 1'b0; tick();
    chk(16'(compareFlag), 16'h0000, "blocked match");
    counterValue = 16'h0000; frc = 2'h1; cyc(1); frc = 2'h0;
    chk(16'({compareFlag[0], compareOutput[0]}), 16'h0000, "force toggle");
    comA = COM_SET; frc = 2'h1; cyc(1); frc = 2'h0;
    chk(16'(compareOutput), 16'h0001, "force set");
    mode = 4'h5; comA = COM_CLEAR; cyc(1);
    chk(16'(compareOutput), 16'h0001, "mode change");
    frc = 2'h1; cyc(1); frc = 2'h0;
    chk(16'(compareOutput), 16'h0001, "force in pwm");
    wr(SEL_CMPA_HIGH, 8'h56); wr(SEL_CMPA_LOW, 8'h78);
    chk(topValueA, 16'h1234, "buffered write");
    rd(SEL_CMPA_LOW); chk(16'(d), 16'h0078, "buffer read");
    atTop = 1'b1; tick(); atTop = 1'b0;
    chk(topValueA, 16'h5678, "reload at top");
    conclude();
  end
endmodule
`default_nettype wire
